//--- include/lcr_defs.vh
// Overview of operation
// - electrode N uses zero-based index N-1
// - scroll register shifts image up by rows
// - fixed lines exempt first 2xFL rows
// - bias ratio code selects 5, 11, 12
// - temperature coefficient code, default zero
// - operating state reports reset, sleep, normal
// - reset-in-progress flag means host not ready
// - power control low bits give panel load
// - power control high bits pick pump source
// - display flags: invert, all on, enable
// - address step control resets to 01H
// - window bounds registers with their defaults
// - scan end, partial start and end rows
// - mapping bits mirror columns and rows
// - line rate field sets line frequency
// - gray shade field sets middle level gap
// - partial display field sets multiplex rate
// - command/data and read/write qualify transfers
// - power-up and system reset restore defaults
// - cursor commands save column pointer to mark and restore it from mark
// - column pointer loaded in two nibbles
// - status read returns fixed byte layout
// - wrap returns column, steps row group; in row-first order it returns row group, steps column
// - display enable bit controls sleep
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH
`define LCR_RST_BR        2'h2
`define LCR_RST_PM        8'hB2
`define LCR_RST_PC        4'hD
`define LCR_RST_AC        5'h01
`define LCR_RST_WINDOW_END_COLUMN      8'h9F
`define LCR_RST_WINDOW_END_ROW_GROUP      5'h1F
`define LCR_RST_ROW_END   7'h7F
`define LCR_RST_LC        9'h008
`define LCR_LAST_COL      8'h9F
`define LCR_LAST_PAGE     5'h1F
`define LCR_OM_RESET      2'h0
`define LCR_OM_SLEEP      2'h2
`define LCR_OM_NORMAL     2'h3
`define LCR_LC_MX         1
`define LCR_LC_MY         2
`define LCR_AC_WA         0
`define LCR_AC_ORDER      1
`define LCR_AC_PID        2
`define LCR_AC_CURSOR     3
`define LCR_DC_ON         2
`define LCR_RESET_CYCLES  16
`endif

//--- logic/lcr_addr_step.v
`timescale 1ns/1ps
`default_nettype none
// column / row-group pointer advance after a data access
module lcr_addr_step (
    input  wire [7:0] i_col,   // current column pointer
    input  wire [4:0] i_page,  // current row-group pointer
    input  wire [4:0] i_ac,    // address step control
    output reg  [7:0] o_col,   // next column pointer
    output reg  [4:0] o_page   // next row-group pointer
);
`include "lcr_defs.vh"
    reg [4:0] page_step;
    always @* begin
        page_step = i_ac[`LCR_AC_PID] ?
                    ((i_page == 5'h00) ? `LCR_LAST_PAGE : i_page - 5'h01) :
                    ((i_page == `LCR_LAST_PAGE) ? 5'h00 : i_page + 5'h01);
        o_col  = i_col;
        o_page = i_page;
        if (!i_ac[`LCR_AC_ORDER]) begin
            if (i_col != `LCR_LAST_COL) begin
                o_col = i_col + 8'h01;
            end else if (i_ac[`LCR_AC_WA]) begin
                o_col  = 8'h00;
                o_page = page_step;
            end
        end else begin
            if ((i_ac[`LCR_AC_PID] ? (i_page != 5'h00) :
                 (i_page != `LCR_LAST_PAGE))) begin
                o_page = page_step;
            end else if (i_ac[`LCR_AC_WA]) begin
                o_page = page_step;
                o_col  = (i_col == `LCR_LAST_COL) ? 8'h00 : i_col + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/lcr_ctrl_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.vh"
module lcr_ctrl_regs #(
    parameter RESET_CYCLES = `LCR_RESET_CYCLES
) (
    input  wire       I_CLK_SYS,      // system clock 40 MHz
    input  wire       I_SRST,         // synchronous reset, high
    input  wire       i_strobe,       // one-cycle host transfer strobe
    input  wire       i_cmd_data,     // 0 control, 1 data
    input  wire       i_rd_wr,        // 0 write, 1 read
    input  wire [7:0] i_wdata,        // host write byte
    input  wire       i_strap,        // strap pin level (async)
    output reg  [7:0] O_RDATA,        // status read byte
    output reg        O_RDATA_VALID,  // status byte valid pulse
    output reg        O_DATA_WR,      // display data write pulse
    output reg        O_DATA_RD,      // display data read pulse
    output reg  [7:0] O_DATA_BYTE,    // display data byte
    output reg        O_BUSY,         // reset in progress
    output reg  [1:0] O_OP_STATE,     // operating state
    output reg  [6:0] O_SCROLL,       // scroll line count
    output reg  [3:0] O_FIXED,        // fixed line count
    output reg  [7:0] O_COL,          // column pointer
    output reg  [4:0] O_PAGE,         // row group pointer
    output reg  [7:0] O_RET_COL,      // return column mark
    output reg  [1:0] O_BIAS,         // bias ratio
    output reg  [1:0] O_TEMP,         // temp coefficient
    output reg  [7:0] O_POT,          // bias potentiometer
    output reg  [3:0] O_PWR,          // power control
    output reg  [2:0] O_DISP,         // display flags
    output reg  [4:0] O_ADDR_CTL,     // address step control
    output reg  [7:0] O_WIN_C0,       // window start column
    output reg  [4:0] O_WIN_P0,       // window start row group
    output reg  [7:0] O_WIN_C1,       // window end column
    output reg  [4:0] O_WIN_P1,       // window end row group
    output reg  [6:0] O_SCAN_END,     // scan end row
    output reg  [6:0] O_PART_START,   // partial start row
    output reg  [6:0] O_PART_END,     // partial end row
    output reg  [8:0] O_MAP,          // panel mapping control
    output reg  [7:0] O_MUX_RATE,     // multiplex rate
    output reg  [7:0] O_VCFG0,        // vendor config 0
    output reg  [7:0] O_VCFG1         // vendor config 1
);
    //--------------------------------------------------------------
    // pending two-byte parameter targets
    //--------------------------------------------------------------
    localparam P_NONE  = 4'h0;
    localparam P_POT   = 4'h1;
    localparam P_VC0   = 4'h2;
    localparam P_VC1   = 4'h3;
    localparam P_TEST  = 4'h4;
    localparam P_CEN   = 4'h5;
    localparam P_DST   = 4'h6;
    localparam P_DEN   = 4'h7;
    localparam P_WC0   = 4'h8;
    localparam P_WP0   = 4'h9;
    localparam P_WC1   = 4'hA;
    localparam P_WP1   = 4'hB;

    reg [3:0] pend;
    reg [7:0] rst_cnt;
    reg       strap_s1;
    reg       strap_s2;
    reg       soft_rst;
    wire [7:0] step_col;
    wire [4:0] step_page;
    wire       in_rst = I_SRST || soft_rst;

    lcr_addr_step u_step (
        .i_col  (O_COL),
        .i_page (O_PAGE),
        .i_ac   (O_ADDR_CTL),
        .o_col  (step_col),
        .o_page (step_page)
    );

    //--------------------------------------------------------------
    // strap synchroniser
    //--------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        strap_s1 <= i_strap;
        strap_s2 <= strap_s1;
    end

    //--------------------------------------------------------------
    // reset sequencing and operating state
    //--------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        if (in_rst) begin
            rst_cnt    <= RESET_CYCLES[7:0];
            O_BUSY     <= 1'b1;
            O_OP_STATE <= `LCR_OM_RESET;
        end else if (rst_cnt != 8'h00) begin
            rst_cnt    <= rst_cnt - 8'h01;
            O_BUSY     <= 1'b1;
            O_OP_STATE <= `LCR_OM_RESET;
        end else begin
            O_BUSY     <= 1'b0;
            O_OP_STATE <= O_DISP[`LCR_DC_ON] ? `LCR_OM_NORMAL
                                             : `LCR_OM_SLEEP;
        end
    end

    //--------------------------------------------------------------
    // multiplex rate from partial display field
    //--------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        if (O_MAP[8:7] == 2'b11)
            O_MUX_RATE <= {1'b0, O_PART_END} - {1'b0, O_PART_START} + 8'h01;
        else
            O_MUX_RATE <= {1'b0, O_SCAN_END} + 8'h01;
    end

    //--------------------------------------------------------------
    // command decoder and register file
    //--------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        O_RDATA_VALID <= 1'b0;
        O_DATA_WR     <= 1'b0;
        O_DATA_RD     <= 1'b0;
        soft_rst      <= 1'b0;
        if (in_rst) begin
            pend         <= P_NONE;
            O_RDATA      <= 8'h00;
            O_DATA_BYTE  <= 8'h00;
            O_SCROLL     <= 7'h00;
            O_FIXED      <= 4'h0;
            O_COL        <= 8'h00;
            O_PAGE       <= 5'h00;
            O_RET_COL    <= 8'h00;
            O_BIAS       <= `LCR_RST_BR;
            O_TEMP       <= 2'h0;
            O_POT        <= `LCR_RST_PM;
            O_PWR        <= `LCR_RST_PC;
            O_DISP       <= 3'h0;
            O_ADDR_CTL   <= `LCR_RST_AC;
            O_WIN_C0     <= 8'h00;
            O_WIN_P0     <= 5'h00;
            O_WIN_C1     <= `LCR_RST_WINDOW_END_COLUMN;
            O_WIN_P1     <= `LCR_RST_WINDOW_END_ROW_GROUP;
            O_SCAN_END   <= `LCR_RST_ROW_END;
            O_PART_START <= 7'h00;
            O_PART_END   <= `LCR_RST_ROW_END;
            O_MAP        <= `LCR_RST_LC;
            O_VCFG0      <= 8'h00;
            O_VCFG1      <= 8'h00;
        end else if (i_strobe && !O_BUSY) begin
            if (i_cmd_data && !i_rd_wr) begin
                O_DATA_WR   <= 1'b1;
                O_DATA_BYTE <= i_wdata;
                O_COL       <= step_col;
                O_PAGE      <= step_page;
            end else if (i_cmd_data) begin
                O_DATA_RD   <= 1'b1;
                O_COL       <= step_col;
                O_PAGE      <= step_page;
            end else if (i_rd_wr) begin
                O_RDATA       <= {strap_s2, O_MAP[`LCR_LC_MX],
                                  O_MAP[`LCR_LC_MY], O_ADDR_CTL[`LCR_AC_WA],
                                  O_DISP[`LCR_DC_ON], O_POT[7:6], 1'b1};
                O_RDATA_VALID <= 1'b1;
            end else if (pend != P_NONE) begin
                pend <= P_NONE;
                case (pend)
                    P_POT:  O_POT        <= i_wdata;
                    P_VC0:  O_VCFG0      <= i_wdata;
                    P_VC1:  O_VCFG1      <= i_wdata;
                    P_CEN:  O_SCAN_END   <= i_wdata[6:0];
                    P_DST:  O_PART_START <= i_wdata[6:0];
                    P_DEN:  O_PART_END   <= i_wdata[6:0];
                    P_WC0:  O_WIN_C0     <= i_wdata;
                    P_WP0:  O_WIN_P0     <= i_wdata[4:0];
                    P_WC1:  O_WIN_C1     <= i_wdata;
                    P_WP1:  O_WIN_P1     <= i_wdata[4:0];
                    default: pend        <= P_NONE;
                endcase
            end else begin
                casez (i_wdata)
                    8'b0000_????: O_COL[3:0] <= i_wdata[3:0];
                    8'b0001_????: O_COL[7:4] <= i_wdata[3:0];
                    8'b0010_01??: O_TEMP     <= i_wdata[1:0];
                    8'b0010_10??: O_PWR[1:0] <= i_wdata[1:0];
                    8'b0010_11??: O_PWR[3:2] <= i_wdata[1:0];
                    8'b0011_000?: pend <= i_wdata[0] ? P_VC1 : P_VC0;
                    8'b0100_????: O_SCROLL[3:0] <= i_wdata[3:0];
                    8'b0101_????: O_SCROLL[6:4] <= i_wdata[2:0];
                    8'b011?_????: O_PAGE <= i_wdata[4:0];
                    8'b1000_0001: pend <= P_POT;
                    8'b1000_01??: O_MAP[8:7] <= i_wdata[1:0];
                    8'b1000_1???: O_ADDR_CTL[2:0] <= i_wdata[2:0];
                    8'b1001_????: O_FIXED <= i_wdata[3:0];
                    8'b1010_00??: O_MAP[4:3] <= i_wdata[1:0];
                    8'b1010_010?: O_DISP[1] <= i_wdata[0];
                    8'b1010_011?: O_DISP[0] <= i_wdata[0];
                    8'b1010_111?: O_DISP[2] <= i_wdata[0];
                    8'b1100_0???: O_MAP[2:0] <= i_wdata[2:0];
                    8'b1101_00??: O_MAP[6:5] <= i_wdata[1:0];
                    8'b1110_0010: soft_rst <= 1'b1;
                    8'b1110_01??: pend <= P_TEST;
                    8'b1110_10??: O_BIAS <= i_wdata[1:0];
                    8'b1110_1110: begin
                        O_ADDR_CTL[`LCR_AC_CURSOR] <= 1'b0;
                        O_COL <= O_RET_COL;
                    end
                    8'b1110_1111: begin
                        O_ADDR_CTL[`LCR_AC_CURSOR] <= 1'b1;
                        O_RET_COL <= O_COL;
                    end
                    8'b1111_0001: pend <= P_CEN;
                    8'b1111_0010: pend <= P_DST;
                    8'b1111_0011: pend <= P_DEN;
                    8'b1111_0100: pend <= P_WC0;
                    8'b1111_0101: pend <= P_WP0;
                    8'b1111_0110: pend <= P_WC1;
                    8'b1111_0111: pend <= P_WP1;
                    8'b1111_100?: O_ADDR_CTL[4] <= i_wdata[0];
                    default: pend <= P_NONE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/lcr_ctrl_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module lcr_chk (
    input wire logic       I_CLK_SYS,     // clock
    input wire logic       I_SRST,        // reset
    input wire logic       i_strobe,      // strobe
    input wire logic       i_cmd_data,    // 0 control 1 data
    input wire logic       i_rd_wr,       // 0 write 1 read
    input wire logic [7:0] i_wdata,       // write byte
    input wire logic [7:0] O_RDATA,       // status byte
    input wire logic       O_RDATA_VALID, // status pulse
    input wire logic       O_DATA_WR,     // write pulse
    input wire logic       O_DATA_RD,     // read pulse
    input wire logic [7:0] O_DATA_BYTE,   // data byte
    input wire logic       O_BUSY,        // busy
    input wire logic [1:0] O_OP_STATE,    // state
    input wire logic [7:0] O_COL,         // column
    input wire logic [4:0] O_PAGE,        // row group
    input wire logic [7:0] O_POT,         // potentiometer
    input wire logic [2:0] O_DISP,        // display flags
    input wire logic [4:0] O_ADDR_CTL,    // address control
    input wire logic [8:0] O_MAP          // mapping
);
    wire tk = i_strobe && !O_BUSY;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    sequence s_settled(logic b);
        (!O_BUSY && O_DISP[2] == b) [*2];
    endsequence
    busy_at_release_a: assert property (
        $fell(I_SRST) |-> O_BUSY) else $error("busy low at release");
    busy_ends_a: assert property (
        $fell(I_SRST) |-> ##[1:40] !O_BUSY) else $error("busy stuck");
    busy_refuse_a: assert property (
        O_BUSY && i_strobe |=> !O_RDATA_VALID && !O_DATA_WR && !O_DATA_RD)
        else $error("transfer taken while busy");
    state_code_a: assert property (
        O_OP_STATE != 2'h1) else $error("unused state code");
    awake_state_a: assert property (
        s_settled(1'b1) |-> O_OP_STATE == 2'h3) else $error("not normal");
    sleep_state_a: assert property (
        s_settled(1'b0) |-> O_OP_STATE == 2'h2) else $error("not asleep");
    status_byte_a: assert property (
        tk && !i_cmd_data && i_rd_wr |=> O_RDATA_VALID && O_RDATA[6:0] ==
        {O_MAP[1], O_MAP[2], O_ADDR_CTL[0], O_DISP[2], O_POT[7:6], 1'b1})
        else $error("bad status byte");
    data_pulse_a: assert property (
        tk && i_cmd_data |=> O_DATA_WR != $past(i_rd_wr) && !O_RDATA_VALID
        && O_DATA_RD == $past(i_rd_wr)
        && ($past(i_rd_wr) || O_DATA_BYTE == $past(i_wdata)))
        else $error("bad data pulse");
    wrap_step_a: assert property (
        tk && i_cmd_data && O_COL == 8'h9F && O_ADDR_CTL[1:0] == 2'b01
        |=> O_COL == 8'h00 && O_PAGE == $past(O_PAGE) +
        (O_ADDR_CTL[2] ? 5'h1F : 5'h01)) else $error("bad wrap");
endmodule
`default_nettype wire

//--- verification/lcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host model
// ----
module lcr_host (
    input  wire logic       clk,  // system clock
    input  wire logic       busy, // device not ready
    output var  logic       stb,  // transfer strobe
    output var  logic       cd,   // 0 control 1 data
    output var  logic       rw,   // 0 write 1 read
    output var  logic [7:0] d     // bus byte
);
    initial begin
        stb = 1'b0;
        cd = 1'b0;
        rw = 1'b0;
        d = 8'h00;
    end
    task automatic xfer(input logic c, input logic r, input logic [7:0] b,
                        input bit go);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #2;
            n++;
        end while (busy && !go && n < 200);
        stb = 1'b1;
        cd = c;
        rw = r;
        d = b;
        @(posedge clk);
        #2;
        stb = 1'b0;
        // released bus shows the inverse byte
        d = ~b;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.vh"
// ----
// bench
// ----
module testbench;
    typedef struct packed {
        logic [6:0] scr; logic [3:0] fix; logic [7:0] col; logic [4:0] pg;
        logic [7:0] ret; logic [1:0] br; logic [1:0] tmp; logic [7:0] pot;
        logic [3:0] pwr; logic [2:0] disp; logic [4:0] ac; logic [7:0] c0;
        logic [4:0] p0; logic [7:0] c1; logic [4:0] p1; logic [6:0] scan;
        logic [6:0] ps; logic [6:0] pe; logic [8:0] map;
    } lcr_regs_t;
    localparam lcr_regs_t DEF = '{7'h00, 4'h0, 8'h00, 5'h00, 8'h00,
        `LCR_RST_BR, 2'h0, `LCR_RST_PM, `LCR_RST_PC, 3'h0, `LCR_RST_AC,
        8'h00, 5'h00, `LCR_RST_WINDOW_END_COLUMN, `LCR_RST_WINDOW_END_ROW_GROUP, `LCR_RST_ROW_END,
        7'h00, `LCR_RST_ROW_END, `LCR_RST_LC};
    logic        clk, srst, strap, stb, cd, rw, vld, busy, ok;
    logic [7:0]  wd, rdata, mux, c;
    logic [1:0]  ost;
    logic [15:0] dir[7] = '{16'hF210, 16'hF360, 16'hF170, 16'h8700,
                            16'hE800, 16'h2D00, 16'hAF00};
    logic [31:0] rs = 32'h9F68B609;
    logic [7:0]  q[$];
    wire lcr_regs_t act;
    lcr_regs_t   e;
    int          n_fail = 0;
    int          n_checks = 0;

    lcr_ctrl_regs #(.RESET_CYCLES(4)) uut (
        .I_CLK_SYS(clk), .I_SRST(srst), .i_strobe(stb), .i_cmd_data(cd),
        .i_rd_wr(rw), .i_wdata(wd), .i_strap(strap), .O_RDATA(rdata),
        .O_RDATA_VALID(vld), .O_DATA_WR(), .O_DATA_RD(), .O_DATA_BYTE(),
        .O_BUSY(busy), .O_OP_STATE(ost), .O_SCROLL(act.scr),
        .O_FIXED(act.fix), .O_COL(act.col), .O_PAGE(act.pg),
        .O_RET_COL(act.ret), .O_BIAS(act.br), .O_TEMP(act.tmp),
        .O_POT(act.pot), .O_PWR(act.pwr), .O_DISP(act.disp),
        .O_ADDR_CTL(act.ac), .O_WIN_C0(act.c0), .O_WIN_P0(act.p0),
        .O_WIN_C1(act.c1), .O_WIN_P1(act.p1), .O_SCAN_END(act.scan),
        .O_PART_START(act.ps), .O_PART_END(act.pe), .O_MAP(act.map),
        .O_MUX_RATE(mux), .O_VCFG0(), .O_VCFG1());
    lcr_host host (.clk(clk), .busy(busy), .stb(stb), .cd(cd), .rw(rw),
                   .d(wd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic lcr_regs_t upd(input lcr_regs_t e,
        input logic [7:0] c, input logic [7:0] p, output logic ok);
        ok = 1'b1;
        casez (c)
            8'b0000_????: e.col[3:0] = c[3:0];
            8'b0001_????: e.col[7:4] = c[3:0];
            8'b0010_01??: e.tmp = c[1:0];
            8'b0010_10??: e.pwr[1:0] = c[1:0];
            8'b0010_11??: e.pwr[3:2] = c[1:0];
            8'b0100_????: e.scr[3:0] = c[3:0];
            8'b0101_????: e.scr[6:4] = c[2:0];
            8'b011?_????: e.pg = c[4:0];
            8'h81: e.pot = p;
            8'b1000_01??: e.map[8:7] = c[1:0];
            8'b1000_1???: e.ac[2:0] = c[2:0];
            8'b1001_????: e.fix = c[3:0];
            8'b1010_00??: e.map[4:3] = c[1:0];
            8'b1010_010?: e.disp[1] = c[0];
            8'b1010_011?: e.disp[0] = c[0];
            8'b1010_111?: e.disp[2] = c[0];
            8'b1100_0???: e.map[2:0] = c[2:0];
            8'b1101_00??: e.map[6:5] = c[1:0];
            8'b1110_10??: e.br = c[1:0];
            8'hE3: ;
            8'hEE: begin
                e.ac[3] = 1'b0;
                e.col = e.ret;
            end
            8'hEF: begin
                e.ac[3] = 1'b1;
                e.ret = e.col;
            end
            8'hF1: e.scan = p[6:0];
            8'hF2: e.ps = p[6:0];
            8'hF3: e.pe = p[6:0];
            8'hF4: e.c0 = p;
            8'hF5: e.p0 = p[4:0];
            8'hF6: e.c1 = p;
            8'hF7: e.p1 = p[4:0];
            8'b1111_100?: e.ac[4] = c[0];
            default: ok = 1'b0;
        endcase
        return e;
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stat;
        q.push_back({strap, e.map[1], e.map[2], e.ac[0], e.disp[2],
                     e.pot[7:6], 1'b1});
        host.xfer(1'b0, 1'b1, 8'h00, 1'b0);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] p);
        lcr_regs_t nx;
        logic      okc;
        nx = upd(e, c, p, okc);
        host.xfer(1'b0, 1'b0, c, 1'b0);
        if (c == 8'h81 || c[7:3] == 5'b11110) begin
            if (p[0])
                stat();
            host.xfer(1'b0, 1'b0, p, 1'b0);
        end
        e = nx;
    endtask

    task automatic cmp;
        logic [7:0] m;
        @(posedge clk);
        #2;
        m = (e.map[8:7] == 2'b11) ? {1'b0, e.pe} - {1'b0, e.ps} + 8'h01
                                  : {1'b0, e.scan} + 8'h01;
        chk(act, e);
        chk(mux, m);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(negedge clk) begin
        if (vld === 1'b1)
            chk(rdata, q.size() ? q.pop_front() : 'x);
    end

    initial begin
        #(25 * 40000);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        srst = 1'b1;
        strap = 1'b0;
        e = DEF;
        repeat (10) @(posedge clk);
        #2 srst = 1'b0;
        host.xfer(1'b0, 1'b0, 8'hE3, 1'b0);
        cmp();
        chk(ost, 2'h2);
        $display("test reset defaults done");
        strap = 1'b1;
        repeat (300) begin
            // only legal commands and ordered rows
            do begin
                rs = lfsr(rs);
                c = rs[7:0];
                void'(upd(e, c, rs[15:8], ok));
            end while (!ok || c inside {8'h85, 8'hE9, 8'h2D, 8'hF1, 8'hF2,
                                         8'hF3});
            strap = rs[17];
            cmd(c, rs[15:8]);
            if (rs[16])
                stat();
            cmp();
        end
        $display("test random commands done");
        foreach (dir[i]) begin
            cmd(dir[i][15:8], dir[i][7:0]);
            cmp();
        end
        $display("test directed commands done");
        for (int k = 0; k < 2; k++) begin
            cmd({5'b10001, k[0], 2'b01}, 8'h00);
            cmd(8'h0F, 8'h00);
            cmd(8'h19, 8'h00);
            cmd({3'b011, k[0] ? 5'h00 : 5'h1F}, 8'h00);
            host.xfer(1'b1, k[0], rs[7:0], 1'b0);
            e.col = 8'h00;
            e.pg = k[0] ? 5'h1F : 5'h00;
            cmp();
        end
        chk(ost, 2'h3);
        $display("test wrap done");
        host.xfer(1'b0, 1'b0, 8'hE2, 1'b0);
        @(posedge clk);
        host.xfer(1'b0, 1'b0, 8'hA5, 1'b1);
        e = DEF;
        host.xfer(1'b0, 1'b0, 8'hE3, 1'b0);
        cmp();
        chk(ost, 2'h2);
        chk(q.size(), 0);
        $display("test system reset done");
        summarize();
    end
endmodule

bind lcr_ctrl_regs lcr_chk u_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .i_strobe(i_strobe),
    .i_cmd_data(i_cmd_data), .i_rd_wr(i_rd_wr), .i_wdata(i_wdata),
    .O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID), .O_DATA_WR(O_DATA_WR),
    .O_DATA_RD(O_DATA_RD), .O_DATA_BYTE(O_DATA_BYTE), .O_BUSY(O_BUSY),
    .O_OP_STATE(O_OP_STATE), .O_COL(O_COL), .O_PAGE(O_PAGE), .O_POT(O_POT),
    .O_DISP(O_DISP), .O_ADDR_CTL(O_ADDR_CTL), .O_MAP(O_MAP));
`default_nettype wire
